// file: verilog/event_ctrl_pkg.sv
/*
 constants, command codes and shared helpers of the module event and control block.
 assumes a single 20 MHz clock domain and a command port that is decoded upstream.
*/
package event_ctrl_pkg;

   // ==========================================================
   // widths and field positions
   localparam int unsigned DATA_W          = 32;
   localparam int unsigned EV_TEMP_BIT     = 14;
   localparam int unsigned EV_SUPPLY_BIT   = 13;
   localparam int unsigned EV_SAFETY_BIT   = 10;
   localparam int unsigned EV_INPUT_BIT    = 6;
   localparam int unsigned EV_SERVICE_BIT  = 4;
   localparam int unsigned CTRL_RAMP_BIT   = 16;
   localparam int unsigned CTRL_KILL_BIT   = 14;
   localparam int unsigned CTRL_FINE_BIT   = 12;
   localparam int unsigned CTRL_ENDIAN_BIT = 11;
   localparam int unsigned CTRL_CLEAR_BIT  = 6;

   // ==========================================================
   // bit groups and reset values
   localparam logic [31:0] MOD_EVENT_BITS  = 32'h0000_6450;
   localparam logic [31:0] MOD_BLOCK_BITS  = 32'h0000_6410;
   localparam logic [31:0] ALL_ONES        = 32'hFFFF_FFFF;
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
   localparam logic [31:0] SUMMARY_RESET   = 32'h0000_0000;
   localparam logic        KILL_RESET      = 1'b0;
   localparam logic        FINE_RESET      = 1'b0;
   localparam logic        BIG_ENDIAN_VAL  = 1'b1;
   localparam logic [1:0]  STRAP_CYCLES    = 2'h3;

   // ==========================================================
   // command codes of the command port
   typedef enum logic [3:0] {
      CMD_READ_MOD_EVENT  = 4'h0,
      CMD_CLEAR_MOD_EVENT = 4'h1,
      CMD_READ_MOD_MASK   = 4'h2,
      CMD_WRITE_MOD_MASK  = 4'h3,
      CMD_READ_CONTROL    = 4'h4,
      CMD_FINE_ADJUST     = 4'h5,
      CMD_KILL_ENABLE     = 4'h6,
      CMD_CLEAR_STATUS    = 4'h7,
      CMD_READ_CHAN_SUM   = 4'h8,
      CMD_CLEAR_CHAN_SUM  = 4'h9,
      CMD_READ_CHAN_MASK  = 4'hA,
      CMD_WRITE_CHAN_MASK = 4'hB
   } cmd_code_t;

   // ==========================================================
   // helpers
   function automatic logic [31:0] sticky_update(input logic [31:0] old_v,
                                                 input logic [31:0] set_v,
                                                 input logic [31:0] clr_v);
      sticky_update = (old_v & ~clr_v) | set_v;
   endfunction : sticky_update

   function automatic logic [31:0] ctrl_word(input logic ramp_off,
                                             input logic kill_en,
                                             input logic fine_en);
      ctrl_word                  = ZERO_WORD;
      ctrl_word[CTRL_RAMP_BIT]   = ramp_off;
      ctrl_word[CTRL_KILL_BIT]   = kill_en;
      ctrl_word[CTRL_FINE_BIT]   = fine_en;
      ctrl_word[CTRL_ENDIAN_BIT] = BIG_ENDIAN_VAL;
      ctrl_word[CTRL_CLEAR_BIT]  = 1'b0;
   endfunction : ctrl_word

endpackage : event_ctrl_pkg

// file: verilog/mod_event_if.sv
/*
 interface between the command side and the module event capture.
 assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
interface mod_event_if;
   logic [31:0] status_cond;
   logic        reject;
   logic [31:0] w1c;
   logic        clear_all;
   logic [31:0] mask;
   logic [31:0] events;
   logic        block_any;
   logic        summary;

   modport ctrl (output status_cond, output reject, output w1c, output clear_all, output mask,
                 input events, input block_any, input summary);
   modport capt (input status_cond, input reject, input w1c, input clear_all, input mask,
                 output events, output block_any, output summary);
endinterface : mod_event_if

// file: verilog/mod_event_capture.sv
/*
 sticky module event bits, hv blocking and module event summary.
 assumes inputs are already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module mod_event_capture
   import event_ctrl_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic arst_n,
   mod_event_if.capt m
);

   typedef struct packed {
      logic [31:0] events;
      logic        block;
      logic        summary;
   } capt_state_t;

   capt_state_t st_r;
   capt_state_t st_nxt;
   logic [31:0] set_v;
   logic [31:0] clr_v;

   // ==========================================================
   // capture
   always_comb begin
      set_v = m.status_cond & MOD_EVENT_BITS;
      set_v[EV_INPUT_BIT] = set_v[EV_INPUT_BIT] | m.reject;
      clr_v = (m.clear_all ? ALL_ONES : m.w1c) & MOD_EVENT_BITS;
      st_nxt = st_r;
      st_nxt.events  = sticky_update(st_r.events, set_v, clr_v);
      st_nxt.block   = |(st_nxt.events & m.mask & MOD_BLOCK_BITS);
      st_nxt.summary = |(st_nxt.events & m.mask);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign m.events    = st_r.events;
   assign m.block_any = st_r.block;
   assign m.summary   = st_r.summary;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_block_tracks_mask: assert property (st_r.block == |(st_r.events & $past(m.mask) & MOD_BLOCK_BITS))
      else $error("blocking does not follow event and mask");
   a_input_not_block: assert property ((st_r.events == 32'h0000_0040) |-> !st_r.block)
      else $error("input error event blocks");
   a_event_sticks: assert property ((|(st_r.events & ~$past(st_r.events))) |->
                                    $past(|(m.status_cond & MOD_EVENT_BITS) || m.reject))
      else $error("event set without cause");
   c_block_seen: cover property (st_r.block ##1 !st_r.block);

endmodule : mod_event_capture

// file: verilog/event_ctrl_top.sv
/*
 module event mask, module control word, channel event summary and channel summary mask.
 assumes a decoded command port on sys_clk and status pins from other clock-free logic,
 which are synchronised here before use.
*/
`timescale 1ns/1ps
module event_ctrl_top
   import event_ctrl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        cmd_valid,
   input  wire cmd_code_t   cmd_code,
   input  wire logic [31:0] cmd_arg,
   input  wire logic [31:0] mod_status_in,
   input  wire logic [31:0] chan_event_status_in,
   input  wire logic [31:0] chan_event_mask_in,
   input  wire logic        delayed_trip_in,
   input  wire logic        ramp_unlimit_strap,
   output logic             rsp_valid_r,
   output logic [31:0]      rsp_data_r,
   output logic             rsp_error_r,
   output logic             kill_enable_r,
   output logic             fine_adjust_r,
   output logic             ramp_limited_r,
   output logic             clear_all_pulse_r,
   output logic             hv_block_r,
   output logic             module_event_summary_r,
   output logic             event_active_summary_flag_r
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [31:0] stat_s1;
      logic [31:0] stat_s2;
      logic [31:0] chev_s1;
      logic [31:0] chev_s2;
      logic [31:0] chmk_s1;
      logic [31:0] chmk_s2;
      logic        trip_s1;
      logic        trip_s2;
      logic        strap_s1;
      logic        strap_s2;
      logic [1:0]  strap_cnt;
      logic        ramp_off;
      logic        kill_en;
      logic        fine_en;
      logic [31:0] mod_mask;
      logic [31:0] chan_summary;
      logic [31:0] chan_sum_mask;
      logic        mod_w1c_go;
      logic [31:0] mod_w1c;
      logic        clear_go;
      logic        reject_go;
      logic        rsp_valid;
      logic [31:0] rsp_data;
      logic        rsp_error;
      logic        ramp_limited;
      logic        event_active;
   } top_state_t;

   top_state_t  st_r;
   top_state_t  st_nxt;
   logic [31:0] chan_set;
   logic [31:0] chan_clr;
   logic        is_cmd;

   mod_event_if mev ();

   mod_event_capture u_capture (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .m       (mev.capt)
   );

   // ==========================================================
   // links to event capture
   assign mev.status_cond = st_r.stat_s2;
   assign mev.reject      = st_r.reject_go;
   assign mev.w1c         = st_r.mod_w1c_go ? st_r.mod_w1c : ZERO_WORD;
   assign mev.clear_all   = st_r.clear_go;
   assign mev.mask        = st_r.mod_mask;

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      is_cmd = cmd_valid;

      // two-stage synchronisers
      st_nxt.stat_s1  = mod_status_in;
      st_nxt.stat_s2  = st_r.stat_s1;
      st_nxt.chev_s1  = chan_event_status_in;
      st_nxt.chev_s2  = st_r.chev_s1;
      st_nxt.chmk_s1  = chan_event_mask_in;
      st_nxt.chmk_s2  = st_r.chmk_s1;
      st_nxt.trip_s1  = delayed_trip_in;
      st_nxt.trip_s2  = st_r.trip_s1;
      st_nxt.strap_s1 = ramp_unlimit_strap;
      st_nxt.strap_s2 = st_r.strap_s1;

      // strap for ramp limit disable sampled in the first three cycles after reset release, then held
      if (st_r.strap_cnt != STRAP_CYCLES) begin
         st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
         st_nxt.ramp_off  = st_r.strap_s2;
      end

      // one-cycle strobes
      st_nxt.mod_w1c_go = 1'b0;
      st_nxt.mod_w1c    = ZERO_WORD;
      st_nxt.clear_go   = 1'b0;
      st_nxt.reject_go  = 1'b0;
      st_nxt.rsp_valid  = 1'b0;
      st_nxt.rsp_error  = 1'b0;
      st_nxt.rsp_data   = ZERO_WORD;
      chan_clr          = ZERO_WORD;

      if (is_cmd) begin
         st_nxt.rsp_valid = 1'b1;
         unique case (cmd_code)
            CMD_READ_MOD_EVENT: begin
               st_nxt.rsp_data = mev.events;
            end
            CMD_CLEAR_MOD_EVENT: begin
               st_nxt.mod_w1c_go = 1'b1;
               st_nxt.mod_w1c    = cmd_arg & MOD_EVENT_BITS;
            end
            CMD_READ_MOD_MASK: begin
               st_nxt.rsp_data = st_r.mod_mask;
            end
            CMD_WRITE_MOD_MASK: begin
               st_nxt.mod_mask = cmd_arg & MOD_EVENT_BITS;
            end
            CMD_READ_CONTROL: begin
               st_nxt.rsp_data = ctrl_word(st_r.ramp_off, st_r.kill_en, st_r.fine_en);
            end
            CMD_FINE_ADJUST: begin
               st_nxt.fine_en = cmd_arg[0];
            end
            CMD_KILL_ENABLE: begin
               st_nxt.kill_en = cmd_arg[0];
            end
            CMD_CLEAR_STATUS: begin
               st_nxt.clear_go = 1'b1;
               chan_clr        = ALL_ONES;
            end
            CMD_READ_CHAN_SUM: begin
               st_nxt.rsp_data = st_r.chan_summary;
            end
            CMD_CLEAR_CHAN_SUM: begin
               chan_clr = cmd_arg;
            end
            CMD_READ_CHAN_MASK: begin
               st_nxt.rsp_data = st_r.chan_sum_mask;
            end
            CMD_WRITE_CHAN_MASK: begin
               st_nxt.chan_sum_mask = cmd_arg;
            end
            default: begin
               st_nxt.rsp_error = 1'b1;
               st_nxt.reject_go = 1'b1;
            end
         endcase
      end

      // channel summary, set wins over clear
      chan_set = st_r.chev_s2 & st_r.chmk_s2;
      st_nxt.chan_summary = sticky_update(st_r.chan_summary, chan_set, chan_clr);
      st_nxt.event_active = |(st_nxt.chan_summary & st_nxt.chan_sum_mask);

      // ramp speed limit
      st_nxt.ramp_limited = (st_nxt.kill_en | st_r.trip_s2) & ~st_nxt.ramp_off;
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r               <= '0;
         st_r.kill_en       <= KILL_RESET;
         st_r.fine_en       <= FINE_RESET;
         st_r.mod_mask      <= MASK_RESET;
         st_r.chan_summary  <= SUMMARY_RESET;
         st_r.chan_sum_mask <= MASK_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign rsp_valid_r                 = st_r.rsp_valid;
   assign rsp_data_r                  = st_r.rsp_data;
   assign rsp_error_r                 = st_r.rsp_error;
   assign kill_enable_r               = st_r.kill_en;
   assign fine_adjust_r               = st_r.fine_en;
   assign ramp_limited_r              = st_r.ramp_limited;
   assign clear_all_pulse_r           = st_r.clear_go;
   assign hv_block_r                  = mev.block_any;
   assign module_event_summary_r      = mev.summary;
   assign event_active_summary_flag_r = st_r.event_active;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_ctrl_read_const: assert property (cmd_valid && cmd_code == CMD_READ_CONTROL |=>
                                       rsp_valid_r && rsp_data_r[CTRL_ENDIAN_BIT] &&
                                       !rsp_data_r[CTRL_CLEAR_BIT])
      else $error("control read shows wrong fixed bits");
   a_kill_by_cmd: assert property (!$stable(kill_enable_r) |->
                                   $past(cmd_valid && cmd_code == CMD_KILL_ENABLE))
      else $error("kill enable changed without kill command");
   a_kill_value: assert property (cmd_valid && cmd_code == CMD_KILL_ENABLE |=>
                                  kill_enable_r == $past(cmd_arg[0]))
      else $error("kill enable not taken from argument");
   a_fine_value: assert property (cmd_valid && cmd_code == CMD_FINE_ADJUST |=>
                                  fine_adjust_r == $past(cmd_arg[0]) ##1 $stable(fine_adjust_r) ||
                                  $past(cmd_valid && cmd_code == CMD_FINE_ADJUST))
      else $error("fine adjust not taken from argument");
   a_ramp_unlimit: assert property (st_r.ramp_off |-> !ramp_limited_r)
      else $error("ramp limited while limit disabled");
   a_chan_set_seen: assert property ((chan_set & ~st_nxt.chan_summary) == ZERO_WORD)
      else $error("channel event lost from summary");
   a_chan_clear_w1c: assert property ((($past(st_r.chan_summary) & ~st_r.chan_summary) &
                                       ~$past(chan_clr)) == ZERO_WORD)
      else $error("summary bit dropped without write of one");
   a_event_active: assert property (event_active_summary_flag_r ==
                                    |(st_r.chan_summary & st_r.chan_sum_mask))
      else $error("event active flag mismatch");
   a_mask_reserved: assert property ((st_r.mod_mask & ~MOD_EVENT_BITS) == ZERO_WORD)
      else $error("reserved mask bit set");
   a_mask_readback: assert property (cmd_valid && cmd_code == CMD_READ_MOD_MASK |=>
                                     rsp_data_r == $past(st_r.mod_mask))
      else $error("mask read back differs");
   a_clear_status: assert property (cmd_valid && cmd_code == CMD_CLEAR_STATUS |=>
                                    clear_all_pulse_r && (st_r.chan_summary & ~$past(chan_set)) == ZERO_WORD
                                    ##1 (mev.events & ~$past(mev.status_cond) & ~32'h0000_0040) == ZERO_WORD)
      else $error("clear status left events");

   c_kill_then_clear: cover property (cmd_valid && cmd_code == CMD_KILL_ENABLE ##[1:8]
                                      cmd_valid && cmd_code == CMD_CLEAR_STATUS);
   c_event_active: cover property ($rose(event_active_summary_flag_r));
   c_hv_block: cover property ($rose(hv_block_r) ##[1:20] $fell(hv_block_r));
   c_reject: cover property (rsp_error_r);

endmodule : event_ctrl_top

// file: verification/module_event_mask_and_control_tb_top.sv
/*
 self-checking testbench of the module event mask, control word, channel summary and channel mask.
 assumes event_ctrl_pkg is compiled first and that assertions live inside the design files.
*/
`timescale 1ns/1ps
module module_event_mask_and_control_tb_top
   import event_ctrl_pkg::*;
;
   // ==========================================================
   // signals and instance
   logic        sys_clk;
   logic        arst_n;
   logic        cmd_valid;
   cmd_code_t   cmd_code;
   logic [31:0] cmd_arg;
   logic [31:0] mod_status_in;
   logic [31:0] chan_event_status_in;
   logic [31:0] chan_event_mask_in;
   logic        delayed_trip_in;
   logic        ramp_unlimit_strap;
   logic        rsp_valid_r;
   logic [31:0] rsp_data_r;
   logic        rsp_error_r;
   logic        kill_enable_r;
   logic        fine_adjust_r;
   logic        ramp_limited_r;
   logic        clear_all_pulse_r;
   logic        hv_block_r;
   logic        module_event_summary_r;
   logic        event_active_summary_flag_r;
   logic [31:0] rd;
   logic        err;
   int          n_mismatch;
   int          check_count;

   event_ctrl_top i_dut (
      .sys_clk                     (sys_clk),
      .arst_n                      (arst_n),
      .cmd_valid                   (cmd_valid),
      .cmd_code                    (cmd_code),
      .cmd_arg                     (cmd_arg),
      .mod_status_in               (mod_status_in),
      .chan_event_status_in        (chan_event_status_in),
      .chan_event_mask_in          (chan_event_mask_in),
      .delayed_trip_in             (delayed_trip_in),
      .ramp_unlimit_strap          (ramp_unlimit_strap),
      .rsp_valid_r                 (rsp_valid_r),
      .rsp_data_r                  (rsp_data_r),
      .rsp_error_r                 (rsp_error_r),
      .kill_enable_r               (kill_enable_r),
      .fine_adjust_r               (fine_adjust_r),
      .ramp_limited_r              (ramp_limited_r),
      .clear_all_pulse_r           (clear_all_pulse_r),
      .hv_block_r                  (hv_block_r),
      .module_event_summary_r      (module_event_summary_r),
      .event_active_summary_flag_r (event_active_summary_flag_r)
   );

   always #25 sys_clk = ~sys_clk;

   // ==========================================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0d ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wait_cyc

   // one command pulse, answer sampled in the cycle it stands
   task automatic send(input cmd_code_t code, input logic [31:0] arg);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_code  = code;
      cmd_arg   = arg;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      rd        = rsp_valid_r ? rsp_data_r : 32'hDEAD_BEEF;
      err       = rsp_error_r;
   endtask : send

   task automatic rd_check(input cmd_code_t code, input logic [31:0] exp);
      send(code, 32'h0000_0000);
      check(rd, exp);
   endtask : rd_check

   task automatic do_reset();
      arst_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      wait_cyc(4);
   endtask : do_reset

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // ==========================================================
   // scenarios
   task automatic t_reset_values();
      rd_check(CMD_READ_MOD_MASK, 32'h0000_0000);
      rd_check(CMD_READ_CHAN_MASK, 32'h0000_0000);
      rd_check(CMD_READ_CHAN_SUM, 32'h0000_0000);
      rd_check(CMD_READ_MOD_EVENT, 32'h0000_0000);
      rd_check(CMD_READ_CONTROL, 32'h0000_0800);
      check({hv_block_r, module_event_summary_r, event_active_summary_flag_r}, 32'h0000_0000);
      $display("test reset_values done");
   endtask : t_reset_values

   task automatic t_mod_mask();
      send(CMD_WRITE_MOD_MASK, 32'hFFFF_FFFF);
      rd_check(CMD_READ_MOD_MASK, 32'h0000_6450);
      send(CMD_WRITE_MOD_MASK, 32'h0000_0400);
      rd_check(CMD_READ_MOD_MASK, 32'h0000_0400);
      send(CMD_WRITE_MOD_MASK, 32'h0000_0000);
      $display("test mod_mask done");
   endtask : t_mod_mask

   task automatic t_control();
      send(CMD_KILL_ENABLE, 32'h0000_0001);
      check(kill_enable_r, 32'h0000_0001);
      check(ramp_limited_r, 32'h0000_0001);
      rd_check(CMD_READ_CONTROL, 32'h0000_4800);
      send(CMD_FINE_ADJUST, 32'h0000_0001);
      check(fine_adjust_r, 32'h0000_0001);
      rd_check(CMD_READ_CONTROL, 32'h0000_5800);
      send(cmd_code_t'(4'hC), 32'hFFFF_FFFF);
      check(err, 32'h0000_0001);
      rd_check(CMD_READ_CONTROL, 32'h0000_5800);
      check(err, 32'h0000_0000);
      rd_check(CMD_READ_MOD_EVENT, 32'h0000_0040);
      send(CMD_WRITE_MOD_MASK, 32'h0000_0040);
      wait_cyc(2);
      check(hv_block_r, 32'h0000_0000);
      check(module_event_summary_r, 32'h0000_0001);
      send(CMD_CLEAR_MOD_EVENT, 32'h0000_0040);
      wait_cyc(2);
      rd_check(CMD_READ_MOD_EVENT, 32'h0000_0000);
      send(CMD_WRITE_MOD_MASK, 32'h0000_0000);
      send(CMD_KILL_ENABLE, 32'h0000_0000);
      check(ramp_limited_r, 32'h0000_0000);
      delayed_trip_in = 1'b1;
      wait_cyc(5);
      check(ramp_limited_r, 32'h0000_0001);
      delayed_trip_in = 1'b0;
      send(CMD_FINE_ADJUST, 32'h0000_0000);
      rd_check(CMD_READ_CONTROL, 32'h0000_0800);
      $display("test control done");
   endtask : t_control

   task automatic t_blocking();
      int unsigned bits[4] = '{EV_TEMP_BIT, EV_SUPPLY_BIT, EV_SAFETY_BIT, EV_SERVICE_BIT};
      logic [31:0] b;
      foreach (bits[i]) begin
         b = 32'h0000_0001 << bits[i];
         mod_status_in = b;
         wait_cyc(5);
         mod_status_in = 32'h0000_0000;
         wait_cyc(5);
         rd_check(CMD_READ_MOD_EVENT, b);
         check(hv_block_r, 32'h0000_0000);
         send(CMD_WRITE_MOD_MASK, b);
         wait_cyc(2);
         check(hv_block_r, 32'h0000_0001);
         check(module_event_summary_r, 32'h0000_0001);
         if (i % 2 == 1) begin
            send(CMD_WRITE_MOD_MASK, 32'h0000_0000);
            wait_cyc(2);
            check(hv_block_r, 32'h0000_0000);
         end
         send(CMD_CLEAR_MOD_EVENT, b);
         wait_cyc(2);
         check(hv_block_r, 32'h0000_0000);
         rd_check(CMD_READ_MOD_EVENT, 32'h0000_0000);
         send(CMD_WRITE_MOD_MASK, 32'h0000_0000);
      end
      $display("test blocking done");
   endtask : t_blocking

   task automatic t_channels();
      chan_event_mask_in   = 32'h8000_0001;
      chan_event_status_in = 32'h8000_0003;
      wait_cyc(5);
      chan_event_status_in = 32'h0000_0000;
      wait_cyc(5);
      rd_check(CMD_READ_CHAN_SUM, 32'h8000_0001);
      check(event_active_summary_flag_r, 32'h0000_0000);
      send(CMD_WRITE_CHAN_MASK, 32'h0000_0001);
      rd_check(CMD_READ_CHAN_MASK, 32'h0000_0001);
      check(event_active_summary_flag_r, 32'h0000_0001);
      send(CMD_CLEAR_CHAN_SUM, 32'h0000_0000);
      rd_check(CMD_READ_CHAN_SUM, 32'h8000_0001);
      send(CMD_CLEAR_CHAN_SUM, 32'h0000_0001);
      wait_cyc(2);
      check(event_active_summary_flag_r, 32'h0000_0000);
      rd_check(CMD_READ_CHAN_SUM, 32'h8000_0000);
      $display("test channels done");
   endtask : t_channels

   task automatic t_clear_all();
      mod_status_in = 32'h0000_2000;
      wait_cyc(5);
      mod_status_in = 32'h0000_0000;
      wait_cyc(5);
      rd_check(CMD_READ_MOD_EVENT, 32'h0000_2000);
      send(CMD_CLEAR_STATUS, 32'h0000_0000);
      check(clear_all_pulse_r, 32'h0000_0001);
      wait_cyc(2);
      rd_check(CMD_READ_CHAN_SUM, 32'h0000_0000);
      rd_check(CMD_READ_MOD_EVENT, 32'h0000_0000);
      rd_check(CMD_READ_CONTROL, 32'h0000_0800);
      $display("test clear_all done");
   endtask : t_clear_all

   task automatic t_ramp_strap();
      ramp_unlimit_strap = 1'b1;
      do_reset();
      rd_check(CMD_READ_CONTROL, 32'h0001_0800);
      send(CMD_KILL_ENABLE, 32'h0000_0001);
      check(kill_enable_r, 32'h0000_0001);
      check(ramp_limited_r, 32'h0000_0000);
      $display("test ramp_strap done");
   endtask : t_ramp_strap

   // ==========================================================
   // main sequence and watchdog
   initial begin
      sys_clk              = 1'b0;
      arst_n               = 1'b0;
      cmd_valid            = 1'b0;
      cmd_code             = CMD_READ_MOD_EVENT;
      cmd_arg              = 32'h0000_0000;
      mod_status_in        = 32'h0000_0000;
      chan_event_status_in = 32'h0000_0000;
      chan_event_mask_in   = 32'h0000_0000;
      delayed_trip_in      = 1'b0;
      ramp_unlimit_strap   = 1'b0;
      n_mismatch           = 0;
      check_count          = 0;
      do_reset();
      t_reset_values();
      t_mod_mask();
      t_control();
      t_blocking();
      t_channels();
      t_clear_all();
      t_ramp_strap();
      finish_test();
   end

   initial begin
      #200_000;
      n_mismatch++;
      $display("watchdog expired at %0d ns", $time);
      finish_test();
   end

endmodule : module_event_mask_and_control_tb_top
